/* File: hdl/fcsd_addr_mux.sv */
// Programmer port address assembly from multiplexed row and column.
// Assumes strobes are single-cycle and synchronous to the clock.
`timescale 1ns/1ns
module fcsd_addr_mux
  import fcsd_pkg::*;
(
  input  wire logic                     i_clock,
  input  wire logic                     i_resetn,
  input  wire logic                     i_row_stb,
  input  wire logic                     i_col_stb,
  input  wire logic [fcsd_pkg::COL_W-1:0] i_addr_pins,
  output logic      [fcsd_pkg::ADDR_W-1:0] o_addr
);

  logic [ROW_W-1:0] row_r;
  logic [ROW_W-1:0] row_nxt;
  logic [COL_W-1:0] col_r;
  logic [COL_W-1:0] col_nxt;

  // Latch row and column halves
  always_comb
  begin
    row_nxt = row_r;
    col_nxt = col_r;
    if (i_row_stb)
      row_nxt = i_addr_pins[ROW_W-1:0];
    if (i_col_stb)
      col_nxt = i_addr_pins;
  end

  always_ff @(posedge i_clock or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      row_r <= '0;
      col_r <= '0;
    end
    else
    begin
      row_r <= row_nxt;
      col_r <= col_nxt;
    end
  end

  // Row forms high bits, column forms low bits
  assign o_addr = {row_r, col_r}; // RQ3 RQ4

endmodule

/* File: hdl/fcsd_pkg.sv */
// Constants and types for the flash command sequence decoder.
// Assumes one 25 MHz clock and write cycles already decoded to a strobe.
//
// Operation
// [RQ1] Each sequence step is one whole host write, never one link clock.
// [RQ2] Only address bits 14..0 and data bits 7..0 are matched.
// [RQ3] Programmer port column address supplies internal address bits 10..0.
// [RQ4] Programmer port row address supplies internal address bits 18..11.
// [RQ5] Sector erase: AA@5555, 55@2AAA, 80@5555, AA@5555, 55@2AAA, 30@sector.
// [RQ6] Byte program: AA@5555, 55@2AAA, A0@5555, then data to target address.
// [RQ7] Identification entry: AA@5555, 55@2AAA, 90@5555.
// [RQ8] Identification exit: AA@5555, 55@2AAA, F0@5555.
// [RQ9] A single F0 write to any address also exits identification.
// [RQ10] Both exit forms return the device to normal array reads.
// [RQ11] Erase sector is the top hex digit of address; sector 7 is boot.
// [RQ12] Identification read: A0 low gives maker code, high gives device code.
// [RQ13] Identification mode is cleared by power loss or reset.
// [RQ14] Identification status bit 2 shows boot lock, bit 3 shows array lock.
// [RQ15] Host link commands are memory writes, start 1110b; reads use 1101b.
// [RQ16] Embedded erase first programs every sector byte to 00.
// [RQ17] A mismatching write abandons the partial sequence.
// [RQ18] Program or erase to a hardware-locked sector is ignored.
package fcsd_pkg;

  localparam logic [14:0] ADDR_UNLOCK1  = 15'h5555;
  localparam logic [14:0] ADDR_UNLOCK2  = 15'h2AAA;
  localparam logic [7:0]  DATA_UNLOCK1  = 8'hAA;
  localparam logic [7:0]  DATA_UNLOCK2  = 8'h55;
  localparam logic [7:0]  CMD_ERASE_SET = 8'h80;
  localparam logic [7:0]  CMD_ERASE_GO  = 8'h30;
  localparam logic [7:0]  CMD_PROGRAM   = 8'hA0;
  localparam logic [7:0]  CMD_ID_ENTRY  = 8'h90;
  localparam logic [7:0]  CMD_ID_EXIT   = 8'hF0;
  localparam logic [7:0]  ERASE_FILL    = 8'h00;
  localparam logic [3:0]  START_MEM_RD  = 4'hD;
  localparam logic [3:0]  START_MEM_WR  = 4'hE;
  localparam logic [2:0]  BOOT_SECTOR   = 3'h7;
  localparam int          BOOT_LOCK_BIT = 2;
  localparam int          ARR_LOCK_BIT  = 3;
  localparam int          ADDR_W        = 19;
  localparam int          SECT_LSB      = 16;
  localparam int          COL_W         = 11;
  localparam int          ROW_W         = 8;
  // Arbitrary identity values
  localparam logic [7:0]  MAKER_CODE    = 8'h5A;
  localparam logic [7:0]  DEVICE_CODE   = 8'hA5;

  typedef enum logic [2:0] {
    FCSD_IDLE,
    FCSD_U1,
    FCSD_U2,
    FCSD_E3,
    FCSD_E4,
    FCSD_E5,
    FCSD_P3
  } fcsd_step_t;

endpackage

/* File: hdl/fcsd_top.sv */
// Command sequence decoder for a 512K x 8 flash array.
// Assumes write transactions arrive as one-cycle strobes from link or port logic.
`timescale 1ns/1ns
module fcsd_top
  import fcsd_pkg::*;
(
  input  wire logic                        i_clock,
  input  wire logic                        i_resetn,
  input  wire logic                        i_sel_prog_port,
  input  wire logic                        i_link_wr,
  input  wire logic                        i_link_rd,
  input  wire logic [fcsd_pkg::ADDR_W-1:0] i_link_addr,
  input  wire logic [7:0]                  i_link_data,
  input  wire logic                        i_pp_row_stb,
  input  wire logic                        i_pp_col_stb,
  input  wire logic [fcsd_pkg::COL_W-1:0]  i_pp_addr,
  input  wire logic                        i_pp_wr,
  input  wire logic                        i_pp_rd,
  input  wire logic [7:0]                  i_pp_data,
  input  wire logic                        i_boot_block_lock_pin_n,
  input  wire logic                        i_protect_pin_n,
  input  wire logic                        i_array_busy,
  input  wire logic [7:0]                  i_array_rdata,
  output logic                             o_id_mode,
  output logic                             o_prog_req,
  output logic [fcsd_pkg::ADDR_W-1:0]      o_prog_addr,
  output logic [7:0]                       o_prog_data,
  output logic                             o_erase_req,
  output logic [2:0]                       o_erase_sector,
  output logic [7:0]                       o_erase_fill,
  output logic                             o_rd_valid,
  output logic [7:0]                       o_rd_data
);

  // ----------------------------------------------------------------
  // Write source selection
  // ----------------------------------------------------------------
  logic [ADDR_W-1:0] pp_addr;
  logic              wr;
  logic              rd;
  logic [ADDR_W-1:0] addr;
  logic [7:0]        data;

  fcsd_addr_mux u_addr_mux (
    .i_clock     (i_clock),
    .i_resetn    (i_resetn),
    .i_row_stb   (i_pp_row_stb),
    .i_col_stb   (i_pp_col_stb),
    .i_addr_pins (i_pp_addr),
    .o_addr      (pp_addr)
  );

  // One strobe per whole write transaction
  assign wr   = i_sel_prog_port ? i_pp_wr : i_link_wr; // RQ1 RQ15
  assign rd   = i_sel_prog_port ? i_pp_rd : i_link_rd;
  assign addr = i_sel_prog_port ? pp_addr : i_link_addr;
  assign data = i_sel_prog_port ? i_pp_data : i_link_data;

  // Sector locked by hardware pins
  function automatic logic sect_locked(input logic [2:0] s, input logic bl_n, input logic wp_n);
    sect_locked = (s == BOOT_SECTOR) ? !bl_n : !wp_n;
  endfunction

  // ----------------------------------------------------------------
  // Sequence decoder
  // ----------------------------------------------------------------
  fcsd_step_t        step_r;
  fcsd_step_t        step_nxt;
  logic              id_r;
  logic              id_nxt;
  logic              prog_r;
  logic              prog_nxt;
  logic              erase_r;
  logic              erase_nxt;
  logic [ADDR_W-1:0] paddr_r;
  logic [ADDR_W-1:0] paddr_nxt;
  logic [7:0]        pdata_r;
  logic [7:0]        pdata_nxt;
  logic [2:0]        sect_r;
  logic [2:0]        sect_nxt;
  logic              is_u1;
  logic              is_u2;
  logic              at_5555;
  logic [2:0]        wsect;

  assign at_5555 = addr[14:0] == ADDR_UNLOCK1; // RQ2
  assign is_u1   = at_5555 && data == DATA_UNLOCK1; // RQ2
  assign is_u2   = addr[14:0] == ADDR_UNLOCK2 && data == DATA_UNLOCK2; // RQ2
  assign wsect   = addr[SECT_LSB+2:SECT_LSB]; // RQ11

  // Next state for command steps
  always_comb
  begin
    step_nxt  = step_r;
    id_nxt    = id_r;
    prog_nxt  = 1'b0;
    erase_nxt = 1'b0;
    paddr_nxt = paddr_r;
    pdata_nxt = pdata_r;
    sect_nxt  = sect_r;
    if (wr && !i_array_busy)
    begin
      step_nxt = FCSD_IDLE; // RQ17
      case (step_r)
        FCSD_IDLE:
        begin
          if (is_u1)
            step_nxt = FCSD_U1;
          else if (data == CMD_ID_EXIT)
            id_nxt = 1'b0; // RQ9 RQ10
        end
        FCSD_U1:
          if (is_u2)
            step_nxt = FCSD_U2;
        FCSD_U2:
          if (at_5555)
          begin
            case (data)
              CMD_ERASE_SET: step_nxt = FCSD_E3; // RQ5
              CMD_PROGRAM:   step_nxt = FCSD_P3; // RQ6
              CMD_ID_ENTRY:  id_nxt = 1'b1; // RQ7
              CMD_ID_EXIT:   id_nxt = 1'b0; // RQ8 RQ10
              default:       step_nxt = FCSD_IDLE;
            endcase
          end
        FCSD_E3:
          if (is_u1)
            step_nxt = FCSD_E4;
        FCSD_E4:
          if (is_u2)
            step_nxt = FCSD_E5;
        FCSD_E5:
          if (data == CMD_ERASE_GO && !sect_locked(wsect, i_boot_block_lock_pin_n,
                                                   i_protect_pin_n)) // RQ5 RQ18
          begin
            erase_nxt = 1'b1;
            sect_nxt  = wsect; // RQ11
          end
        FCSD_P3:
          if (!sect_locked(wsect, i_boot_block_lock_pin_n, i_protect_pin_n)) // RQ18
          begin
            prog_nxt  = 1'b1; // RQ6
            paddr_nxt = addr;
            pdata_nxt = data;
          end
        default:
          step_nxt = FCSD_IDLE;
      endcase
    end
  end

  // Sequence registers; reset leaves normal read mode
  always_ff @(posedge i_clock or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      step_r  <= FCSD_IDLE;
      id_r    <= 1'b0; // RQ13
      prog_r  <= 1'b0;
      erase_r <= 1'b0;
      paddr_r <= '0;
      pdata_r <= '0;
      sect_r  <= '0;
    end
    else
    begin
      step_r  <= step_nxt;
      id_r    <= id_nxt;
      prog_r  <= prog_nxt;
      erase_r <= erase_nxt;
      paddr_r <= paddr_nxt;
      pdata_r <= pdata_nxt;
      sect_r  <= sect_nxt;
    end
  end

  assign o_id_mode      = id_r;
  assign o_prog_req     = prog_r;
  assign o_prog_addr    = paddr_r;
  assign o_prog_data    = pdata_r;
  assign o_erase_req    = erase_r;
  assign o_erase_sector = sect_r;
  assign o_erase_fill   = ERASE_FILL; // RQ16

  // ----------------------------------------------------------------
  // Read data path
  // ----------------------------------------------------------------
  logic       rdv_r;
  logic       rdv_nxt;
  logic [7:0] rdd_r;
  logic [7:0] rdd_nxt;

  // Identification codes and lock status, else array data
  always_comb
  begin
    rdv_nxt = rd;
    rdd_nxt = rdd_r;
    if (rd)
    begin
      if (!id_r)
        rdd_nxt = i_array_rdata; // RQ10
      else if (addr[ADDR_W-1:1] != '0)
        rdd_nxt = 8'h00;
      else
        rdd_nxt = addr[0] ? DEVICE_CODE : MAKER_CODE; // RQ12
      if (id_r)
      begin
        rdd_nxt[BOOT_LOCK_BIT] = !i_boot_block_lock_pin_n; // RQ14
        rdd_nxt[ARR_LOCK_BIT]  = !i_protect_pin_n; // RQ14
      end
    end
  end

  always_ff @(posedge i_clock or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      rdv_r <= 1'b0;
      rdd_r <= '0;
    end
    else
    begin
      rdv_r <= rdv_nxt;
      rdd_r <= rdd_nxt;
    end
  end

  assign o_rd_valid = rdv_r;
  assign o_rd_data  = rdd_r;

endmodule

/* File: tb/fcsd_chk.sv */
// Port checker for the command sequence decoder.
// Assumes it is bound onto fcsd_top; one clock, async active-low reset.
`timescale 1ns/1ns
module fcsd_chk
  import fcsd_pkg::*;
(
  input wire logic                   i_clock,
  input wire logic                   i_resetn,
  input wire logic                   i_sel_prog_port,
  input wire logic                   i_link_wr,
  input wire logic                   i_link_rd,
  input wire logic [fcsd_pkg::ADDR_W-1:0] i_link_addr,
  input wire logic [7:0]             i_link_data,
  input wire logic                   i_pp_wr,
  input wire logic                   i_pp_rd,
  input wire logic                   i_boot_block_lock_pin_n,
  input wire logic                   i_protect_pin_n,
  input wire logic [7:0]             i_array_rdata,
  input wire logic                   o_id_mode,
  input wire logic                   o_prog_req,
  input wire logic [fcsd_pkg::ADDR_W-1:0] o_prog_addr,
  input wire logic [7:0]             o_prog_data,
  input wire logic                   o_erase_req,
  input wire logic [2:0]             o_erase_sector,
  input wire logic [7:0]             o_erase_fill,
  input wire logic                   o_rd_valid,
  input wire logic [7:0]             o_rd_data
);
  logic [2:0] link_sect;
  // ----------------------------------------
  // Relations between inputs and answers
  // ----------------------------------------
  assign link_sect = i_link_addr[18:16];
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!i_resetn);
  fill_zero_a: assert property (o_erase_fill == ERASE_FILL)
    else $error("erase fill not zero");
  prog_pulse_a: assert property (o_prog_req |=> !o_prog_req)
    else $error("program request longer than one cycle");
  req_cause_a: assert property ((o_prog_req || o_erase_req) |-> $past(i_link_wr || i_pp_wr))
    else $error("request without a write");
  lock_drop_a: assert property (o_erase_req |-> (o_erase_sector == BOOT_SECTOR ?
    $past(i_boot_block_lock_pin_n) : $past(i_protect_pin_n))) else $error("locked erase issued");
  erase_sect_a: assert property (o_erase_req && !$past(i_sel_prog_port)
    |-> o_erase_sector == $past(link_sect)) else $error("erase sector wrong");
  prog_addr_a: assert property (o_prog_req && !$past(i_sel_prog_port) |->
    o_prog_addr == $past(i_link_addr) && o_prog_data == $past(i_link_data))
    else $error("program target wrong");
  rd_valid_a: assert property ((i_link_rd && !i_sel_prog_port) || (i_pp_rd && i_sel_prog_port)
    |=> o_rd_valid) else $error("read not answered");
  id_rd_a: assert property (o_id_mode && i_link_rd && !i_sel_prog_port && i_link_addr == 19'h0
    |=> o_rd_data == {MAKER_CODE[7:4], ~$past(i_protect_pin_n),
    ~$past(i_boot_block_lock_pin_n), MAKER_CODE[1:0]}) else $error("maker code wrong");
  norm_rd_a: assert property (!o_id_mode && i_link_rd && !i_sel_prog_port
    |=> o_rd_data == $past(i_array_rdata)) else $error("array read wrong");
  id_hold_a: assert property (!i_link_wr && !i_pp_wr |=> $stable(o_id_mode))
    else $error("mode changed without a write");
endmodule
bind fcsd_top fcsd_chk u_chk (
  .i_clock(i_clock), .i_resetn(i_resetn), .i_sel_prog_port(i_sel_prog_port),
  .i_link_wr(i_link_wr), .i_link_rd(i_link_rd), .i_link_addr(i_link_addr),
  .i_link_data(i_link_data), .i_pp_wr(i_pp_wr), .i_pp_rd(i_pp_rd),
  .i_boot_block_lock_pin_n(i_boot_block_lock_pin_n), .i_protect_pin_n(i_protect_pin_n),
  .i_array_rdata(i_array_rdata), .o_id_mode(o_id_mode), .o_prog_req(o_prog_req),
  .o_prog_addr(o_prog_addr), .o_prog_data(o_prog_data), .o_erase_req(o_erase_req),
  .o_erase_sector(o_erase_sector), .o_erase_fill(o_erase_fill), .o_rd_valid(o_rd_valid),
  .o_rd_data(o_rd_data));

/* File: tb/fcsd_host.sv */
// Host model issuing whole command write cycles on link or programmer port.
// Assumes i_sel follows the decoder's port select.
`timescale 1ns/1ns
module fcsd_host
  import fcsd_pkg::*;
(
  input  wire logic        i_clock,
  input  wire logic        i_sel,
  output logic             o_wr,
  output logic             o_rd,
  output logic [18:0]      o_addr,
  output logic [7:0]       o_data,
  output logic             o_row,
  output logic             o_col,
  output logic [10:0]      o_pa,
  output logic             o_pwr,
  output logic             o_prd
);
  // ----------------------------------------
  // One pulse per complete memory write
  // ----------------------------------------
  initial {o_wr, o_rd, o_row, o_col, o_pwr, o_prd, o_addr, o_data, o_pa} = '0;
  // Row then column strobe on the multiplexed pins
  task automatic adr(input logic [18:0] a);
    @(posedge i_clock) #1;
    o_row = 1'b1;
    o_pa = {3'h0, a[18:11]};
    @(posedge i_clock) #1;
    o_row = 1'b0;
    o_col = 1'b1;
    o_pa = a[10:0];
  endtask
  task automatic w(input logic [18:0] a, input logic [7:0] d);
    if (i_sel)
    begin
      adr(a);
      @(posedge i_clock) #1;
      o_col = 1'b0;
      o_pwr = 1'b1;
      o_data = d;
      @(posedge i_clock) #1;
      o_pwr = 1'b0;
      o_pa = ~o_pa;
    end
    else
    begin
      @(posedge i_clock) #1;
      o_wr = 1'b1;
      o_addr = a;
      o_data = d;
      @(posedge i_clock) #1;
      o_wr = 1'b0;
      o_addr = ~a;
    end
    o_data = ~d;
  endtask
  // Memory read cycle
  task automatic r(input logic [18:0] a);
    if (i_sel)
    begin
      adr(a);
      @(posedge i_clock) #1;
      o_col = 1'b0;
      o_prd = 1'b1;
      @(posedge i_clock) #1;
      o_prd = 1'b0;
      o_pa = ~o_pa;
    end
    else
    begin
      @(posedge i_clock) #1;
      o_rd = 1'b1;
      o_addr = a;
      @(posedge i_clock) #1;
      o_rd = 1'b0;
      o_addr = ~a;
    end
  endtask
endmodule

/* File: tb/tb_top.sv */
// Self-checking bench for the command sequence decoder.
// Assumes fcsd_host issues writes; the checker is bound onto fcsd_top.
`timescale 1ns/1ns
module tb_top;
  import fcsd_pkg::*;
  logic        i_clock = 1'b0;
  logic        i_resetn = 1'b0;
  logic        sel = 1'b0;
  logic        boot_n = 1'b1;
  logic        prot_n = 1'b1;
  logic        busy = 1'b0;
  logic [7:0]  rdata = 8'h00;
  logic        wr, rd, row, col, pwr, prd, id, preq, ereq, rv;
  logic [18:0] addr, paddr, a;
  logic [7:0]  data, pdat, rdat, d;
  logic [10:0] pa;
  logic [2:0]  esec;
  logic [31:0] q[$];
  int          n_mismatch = 0;
  int          checked = 0;
  int          seed = 32'hab4e97a5;
  // ----------------------------------------
  // Clock, models and result watcher
  // ----------------------------------------
  always #20 i_clock = ~i_clock;
  fcsd_host u_host (.i_clock(i_clock), .i_sel(sel), .o_wr(wr), .o_rd(rd), .o_addr(addr),
    .o_data(data), .o_row(row), .o_col(col), .o_pa(pa), .o_pwr(pwr), .o_prd(prd));
  fcsd_top u_dut (.i_clock(i_clock), .i_resetn(i_resetn), .i_sel_prog_port(sel),
    .i_link_wr(wr), .i_link_rd(rd), .i_link_addr(addr), .i_link_data(data),
    .i_pp_row_stb(row), .i_pp_col_stb(col), .i_pp_addr(pa), .i_pp_wr(pwr), .i_pp_rd(prd),
    .i_pp_data(data), .i_boot_block_lock_pin_n(boot_n), .i_protect_pin_n(prot_n),
    .i_array_busy(busy), .i_array_rdata(rdata), .o_id_mode(id), .o_prog_req(preq),
    .o_prog_addr(paddr), .o_prog_data(pdat), .o_erase_req(ereq), .o_erase_sector(esec),
    .o_erase_fill(), .o_rd_valid(rv), .o_rd_data(rdat));
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  function automatic logic [31:0] nxt();
    nxt = (q.size() == 0) ? 32'h0 : q.pop_front();
  endfunction
  // Oldest note against each answer
  always @(negedge i_clock)
  begin
    if (preq) chk({4'h1, 1'b0, paddr, pdat}, nxt());
    if (ereq) chk({4'h2, 25'h0, esec}, nxt());
    if (rv) chk({4'h3, 20'h0, rdat}, nxt());
  end
  task automatic cmd(input logic [7:0] c);
    logic [3:0] r;
    r = 4'($random(seed));
    u_host.w({r, ADDR_UNLOCK1}, DATA_UNLOCK1);
    u_host.w({~r, ADDR_UNLOCK2}, DATA_UNLOCK2);
    u_host.w({4'h0, ADDR_UNLOCK1}, c);
  endtask
  // Six-write erase: set-up command, second unlock pair, then go at the sector
  task automatic ers(input logic [18:0] sa);
    cmd(CMD_ERASE_SET);
    u_host.w({4'h0, ADDR_UNLOCK1}, DATA_UNLOCK1);
    u_host.w({4'h0, ADDR_UNLOCK2}, DATA_UNLOCK2);
    u_host.w(sa, CMD_ERASE_GO);
  endtask
  task automatic tend(input string nm);
    repeat (3) @(posedge i_clock);
    chk(32'(q.size()), 32'h0);
    $display("test %s done", nm);
  endtask
  function automatic logic [7:0] idv(input logic [7:0] c);
    idv = c;
    idv[BOOT_LOCK_BIT] = ~boot_n;
    idv[ARR_LOCK_BIT] = ~prot_n;
  endfunction
  task automatic finish_test();
    $display("checked %0d mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  // Watchdog
  initial
  begin
    #200000;
    n_mismatch++;
    finish_test();
  end
  // Main sequence
  initial
  begin
    repeat (20) @(posedge i_clock);
    #1 i_resetn = 1'b1;
    chk({31'h0, id}, 32'h0);
    for (int p = 0; p < 6; p++)
    begin
      sel = p[0];
      a = 19'($random(seed));
      d = 8'($random(seed));
      q.push_back({4'h1, 1'b0, a, d});
      cmd(CMD_PROGRAM);
      u_host.w(a, d);
    end
    sel = 1'b0;
    tend("program");
    for (int s = 0; s < 10; s++)
    begin
      boot_n = (s != 8);
      prot_n = (s != 9);
      if (s < 8) q.push_back({4'h2, 25'h0, 3'(s)});
      ers({s < 8 ? 3'(s) : (s == 8 ? 3'h7 : 3'h2), 16'($random(seed))});
    end
    prot_n = 1'b1;
    tend("erase");
    cmd(8'h12);
    u_host.w(19'h01234, 8'h77);
    cmd(CMD_PROGRAM);
    busy = 1'b1;
    u_host.w(19'h01234, 8'h66);
    busy = 1'b0;
    q.push_back({4'h1, 1'b0, 19'h01234, 8'h77});
    u_host.w(19'h01234, 8'h77);
    tend("guard");
    for (int k = 0; k < 3; k++)
    begin
      sel = (k == 1);
      cmd(CMD_ID_ENTRY);
      @(negedge i_clock);
      chk({31'h0, id}, 32'h1);
      for (int b = 0; b < 4; b++)
      begin
        {boot_n, prot_n} = 2'(b);
        q.push_back({4'h3, 20'h0, idv(MAKER_CODE)});
        u_host.r(19'h0);
        q.push_back({4'h3, 20'h0, idv(DEVICE_CODE)});
        u_host.r(19'h1);
        q.push_back({4'h3, 20'h0, idv(8'h00)});
        u_host.r(19'h2);
      end
      if (k == 0) cmd(CMD_ID_EXIT);
      else if (k == 1) u_host.w(19'($random(seed)), CMD_ID_EXIT);
      else
      begin
        @(posedge i_clock) #1;
        i_resetn = 1'b0;
        @(posedge i_clock);
      end
      @(negedge i_clock);
      i_resetn = 1'b1;
      chk({31'h0, id}, 32'h0);
      rdata = 8'($random(seed));
      q.push_back({4'h3, 20'h0, rdata});
      u_host.r(19'h0);
    end
    sel = 1'b0;
    tend("ident");
    finish_test();
  end
endmodule
